// ==== rtl/uart_rx_consts.svh ====
// Constants for the serial receiver: buffer entry layout, frame sizes, sample rates.
// Assumes inclusion by bare name from the package, the buffer and the receiver module.
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH

// Receive buffer entry layout
`define RX_ENTRY_W 12
`define RX_NINTH_POS 8
`define RX_PE_POS 9
`define RX_DOR_POS 10
`define RX_FE_POS 11
`define RX_BUF_DEPTH 2

// Frame format codes
`define RX_CSZ_NINE 3'h7
`define RX_SHREG_W 9
`define RX_PAR_EN_POS 1
`define RX_PAR_ODD_POS 0

// Samples per bit in asynchronous mode
`define RX_SPB_NORMAL 5'h10
`define RX_SPB_DOUBLE 5'h08

`endif

// ==== rtl/uart_rx_pkg.sv ====
// Types and helper functions shared by the serial receiver modules.
// Assumes uart_rx_consts.svh is on the include path.
`include "uart_rx_consts.svh"

package uart_rx_pkg;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_type;

  // Majority of three samples
  function automatic logic majority3(input logic [2:0] s);
    majority3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority3

  // Data bits per character from the size code
  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    if (csz == `RX_CSZ_NINE) begin
      data_bits = 4'h9;
    end else begin
      data_bits = 4'h5 + {2'h0, csz[1:0]};
    end
  endfunction : data_bits

  // Right-justify an LSB-first shift register holding n bits; upper bits become zero
  function automatic logic [8:0] align_bits(input logic [8:0] sh, input logic [3:0] n);
    align_bits = sh >> (4'h9 - n);
  endfunction : align_bits

endpackage : uart_rx_pkg

// ==== rtl/uart_rx_pin_sync.sv ====
// Two-flop synchronisers for the serial data pin and the external transfer clock pin.
// Assumes both pins are asynchronous to sys_clk_i; the clock pin is slow enough to be sampled.
module uart_rx_pin_sync (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Pins
  input wire logic serial_pin_i,
  input wire logic xck_pin_i,
  // Synchronised
  output logic line_o,
  output logic xck_rise_o
);

  typedef struct packed {
    logic [1:0] line;
    logic [2:0] xck;
  } sync_type;

  sync_type r_q;
  sync_type r_d;

  always_comb begin
    r_d = r_q;
    r_d.line = {r_q.line[0], serial_pin_i};
    r_d.xck = {r_q.xck[1:0], xck_pin_i};
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      // Line idles high
      r_q <= '{line: 2'h3, xck: 3'h0};
    end else begin
      r_q <= r_d;
    end
  end

  // Edge taken from stages two and three only
  assign line_o = r_q.line[1];
  assign xck_rise_o = r_q.xck[1] & ~r_q.xck[2];

endmodule : uart_rx_pin_sync

// ==== rtl/uart_rx_buffer.sv ====
// Two-entry receive buffer; head entry and its valid bit come out of registers.
// Assumes push only when not full; pop while empty is ignored; flush wins over all.
`include "uart_rx_consts.svh"

module uart_rx_buffer #(
  parameter int WIDTH = `RX_ENTRY_W,
  parameter int DEPTH = `RX_BUF_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  // State
  output logic full_o,
  output logic head_valid_o,
  output logic [WIDTH-1:0] head_data_o
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
    logic head_valid;
    logic [WIDTH-1:0] head;
  } buf_type;

  buf_type r_q;
  buf_type r_d;
  logic do_push;
  logic do_pop;

  always_comb begin
    r_d = r_q;
    do_push = push_i && (r_q.cnt != (PW+1)'(DEPTH));
    do_pop = pop_i && (r_q.cnt != '0);
    if (do_push) begin
      r_d.mem[r_q.wp] = push_data_i;
      r_d.wp = (r_q.wp == PW'(DEPTH - 1)) ? '0 : r_q.wp + 1'b1;
    end
    if (do_pop) begin
      r_d.rp = (r_q.rp == PW'(DEPTH - 1)) ? '0 : r_q.rp + 1'b1;
    end
    r_d.cnt = r_q.cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
    // Head lags the pointers by one cycle
    r_d.head_valid = r_q.cnt != '0;
    r_d.head = r_q.mem[r_q.rp];
    if (flush_i) begin
      r_d.wp = '0;
      r_d.rp = '0;
      r_d.cnt = '0;
      r_d.head_valid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign full_o = r_q.cnt == (PW+1)'(DEPTH);
  assign head_valid_o = r_q.head_valid;
  assign head_data_o = r_q.head;

endmodule : uart_rx_buffer

// ==== rtl/uart_serial_receiver.sv ====
// Receive half of a serial port: start detection, majority sampling, shift register,
// two-entry receive buffer with ninth bit and error flags, receive-complete request.
// Assumes sample_tick_i comes from a baud divider on sys_clk_i at 16x (8x double speed) the bit rate.
// Assumes both pins are asynchronous and only reach the logic through the synchroniser.
`include "uart_rx_consts.svh"

module uart_serial_receiver (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Configuration
  input wire logic receive_enable_i,
  input wire logic sync_mode_i,
  input wire logic double_speed_bit_i,
  input wire logic [2:0] char_size_field_i,
  input wire logic [1:0] parity_mode_field_i,
  input wire logic stop_bits_select_i,
  input wire logic rx_complete_irq_enable_i,
  input wire logic global_irq_enable_i,
  // Sample rate enable from the baud divider
  input wire logic sample_tick_i,
  // Pins
  input wire logic serial_input_pin_i,
  input wire logic ext_transfer_clock_pin_i,
  // Data register read strobe
  input wire logic data_read_i,
  // Receive data register and status
  output logic [7:0] rx_data_register_o,
  output logic rx_ninth_bit_o,
  output logic frame_error_flag_o,
  output logic data_overrun_flag_o,
  output logic parity_error_flag_o,
  output logic rx_complete_flag_o,
  output logic rx_complete_irq_o,
  output logic pin_override_o
);

  import uart_rx_pkg::*;

  typedef struct packed {
    rx_state_type state;
    logic [4:0] smp_cnt;
    logic [1:0] votes;
    logic [3:0] bit_cnt;
    logic [8:0] shreg;
    logic par_bit;
    logic pend;
    logic [`RX_ENTRY_W-1:0] pend_entry;
    logic lost;
    logic [7:0] data;
    logic ninth;
    logic fe;
    logic data_overrun_flag;
    logic pe;
    logic rx_complete_flag;
    logic irq;
    logic ovr;
  } rx_type;

  rx_type r_q;
  rx_type r_d;

  logic line;
  logic xck_rise;
  logic buf_full;
  logic head_valid;
  logic [`RX_ENTRY_W-1:0] head_data;
  logic push;
  logic [`RX_ENTRY_W-1:0] push_data;
  logic flush;

  // Pins cross into the system clock domain here
  uart_rx_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .serial_pin_i(serial_input_pin_i),
    .xck_pin_i(ext_transfer_clock_pin_i),
    .line_o(line),
    .xck_rise_o(xck_rise)
  );

  // Flush empties the buffer in the disable cycle itself
  uart_rx_buffer #(
    .WIDTH(`RX_ENTRY_W),
    .DEPTH(`RX_BUF_DEPTH)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .flush_i(flush),
    .push_i(push),
    .push_data_i(push_data),
    .pop_i(data_read_i),
    .full_o(buf_full),
    .head_valid_o(head_valid),
    .head_data_o(head_data)
  );

  // Per-cycle frame decoding
  logic [4:0] spb;
  logic [4:0] first_smp;
  logic [4:0] last_smp;
  logic [3:0] nbits;
  logic par_en;
  logic bit_ok;
  logic bit_val;
  logic start_seen;
  logic frame_done;
  logic [8:0] aligned;
  logic [`RX_ENTRY_W-1:0] new_entry;

  always_comb begin
    r_d = r_q;
    push = 1'b0;
    push_data = '0;
    bit_ok = 1'b0;
    bit_val = 1'b1;
    start_seen = 1'b0;
    frame_done = 1'b0;
    new_entry = '0;
    spb = double_speed_bit_i ? `RX_SPB_DOUBLE : `RX_SPB_NORMAL;
    first_smp = spb >> 1;
    last_smp = first_smp + 5'h02;
    nbits = data_bits(char_size_field_i);
    par_en = parity_mode_field_i[`RX_PAR_EN_POS];

    // Bit decisions: centre-sample vote, or one sample per rising transfer clock edge
    if (!sync_mode_i) begin
      if (sample_tick_i && r_q.state != RX_IDLE) begin
        if (r_q.smp_cnt >= first_smp && r_q.smp_cnt < last_smp) begin
          r_d.votes = {r_q.votes[0], line};
        end
        if (r_q.smp_cnt == last_smp) begin
          bit_ok = 1'b1;
          bit_val = majority3({r_q.votes, line});
        end
        r_d.smp_cnt = (r_q.smp_cnt == spb) ? 5'h01 : r_q.smp_cnt + 5'h01;
      end
    end else begin
      bit_ok = xck_rise && r_q.state != RX_IDLE;
      bit_val = line;
    end

    unique case (r_q.state)
      RX_IDLE: begin
        // First low sample counts as sample one of the start bit
        if (!sync_mode_i && sample_tick_i && !line) begin
          r_d.state = RX_START;
          r_d.smp_cnt = 5'h02;
        end else if (sync_mode_i && xck_rise && !line) begin
          r_d.state = RX_DATA;
          r_d.bit_cnt = '0;
          start_seen = 1'b1;
        end
      end
      RX_START: begin
        if (bit_ok) begin
          // Majority high means a noise spike
          if (bit_val) begin
            r_d.state = RX_IDLE;
          end else begin
            r_d.state = RX_DATA;
            r_d.bit_cnt = '0;
            start_seen = 1'b1;
          end
        end
      end
      RX_DATA: begin
        if (bit_ok) begin
          r_d.shreg = {bit_val, r_q.shreg[8:1]};
          r_d.bit_cnt = r_q.bit_cnt + 4'h1;
          if (r_q.bit_cnt + 4'h1 == nbits) begin
            r_d.state = par_en ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        // Parity bit kept out of the shift register so data stays aligned
        if (bit_ok) begin
          r_d.par_bit = bit_val;
          r_d.state = RX_STOP;
        end
      end
      RX_STOP: begin
        // Back to idle after the first stop bit; a second one is just idle line
        if (bit_ok) begin
          frame_done = 1'b1;
          r_d.state = RX_IDLE;
        end
      end
      // Unused state codes fall back to idle
      default: begin
        r_d.state = RX_IDLE;
      end
    endcase

    // Frame assembly; short characters land right-justified with zero upper bits
    aligned = align_bits(r_q.shreg, nbits);
    new_entry[7:0] = aligned[7:0];
    new_entry[`RX_NINTH_POS] = (char_size_field_i == `RX_CSZ_NINE) ? aligned[8] : 1'b0;
    new_entry[`RX_FE_POS] = ~bit_val;
    new_entry[`RX_PE_POS] = par_en && ((^aligned ^ r_q.par_bit) != parity_mode_field_i[`RX_PAR_ODD_POS]);

    // A waiting frame drains first; overrun mark rides on the entry that goes in
    if (r_q.pend && !buf_full) begin
      push = 1'b1;
      push_data = r_q.pend_entry;
      push_data[`RX_DOR_POS] = r_q.lost;
      r_d.lost = 1'b0;
      r_d.pend = 1'b0;
      if (frame_done) begin
        r_d.pend = 1'b1;
        r_d.pend_entry = new_entry;
      end
    end else if (frame_done) begin
      if (!buf_full && !r_q.pend) begin
        push = 1'b1;
        push_data = new_entry;
        push_data[`RX_DOR_POS] = r_q.lost;
        r_d.lost = 1'b0;
      end else begin
        // Overwrites any older waiting frame, already counted as lost
        r_d.pend = 1'b1;
        r_d.pend_entry = new_entry;
      end
    end

    if (start_seen && buf_full && r_q.pend) begin
      r_d.lost = 1'b1;
    end

    // Disable acts at once: frame in flight and waiting frame are dropped
    flush = ~receive_enable_i;
    if (!receive_enable_i) begin
      r_d.state = RX_IDLE;
      r_d.pend = 1'b0;
      r_d.lost = 1'b0;
      push = 1'b0;
    end
    // Pin claimed one cycle after enable, released one cycle after disable
    r_d.ovr = receive_enable_i;

    // Register view of the head entry; error flags have no write path
    r_d.rx_complete_flag = head_valid && !flush;
    // Masked by the flush too, so data and flags clear in the same cycle as the flag
    if (r_d.rx_complete_flag) begin
      r_d.data = head_data[7:0];
      r_d.ninth = head_data[`RX_NINTH_POS];
      r_d.fe = head_data[`RX_FE_POS];
      r_d.data_overrun_flag = head_data[`RX_DOR_POS];
      r_d.pe = head_data[`RX_PE_POS];
    end else begin
      r_d.data = 8'h00;
      r_d.ninth = 1'b0;
      r_d.fe = 1'b0;
      r_d.data_overrun_flag = 1'b0;
      r_d.pe = 1'b0;
    end
    // Level request from the completion flag only, never from errors
    r_d.irq = r_d.rx_complete_flag && rx_complete_irq_enable_i && global_irq_enable_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      r_q <= '{state: RX_IDLE, smp_cnt: 5'h01, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign rx_data_register_o = r_q.data;
  assign rx_ninth_bit_o = r_q.ninth;
  assign frame_error_flag_o = r_q.fe;
  assign data_overrun_flag_o = r_q.data_overrun_flag;
  assign parity_error_flag_o = r_q.pe;
  assign rx_complete_flag_o = r_q.rx_complete_flag;
  assign rx_complete_irq_o = r_q.irq;
  assign pin_override_o = r_q.ovr;

endmodule : uart_serial_receiver

// ==== tb/uart_serial_receiver_properties.sv ====
// Concurrent checks on the serial receiver's ports.
// Assumes the bind below; every signal the checks use is in the system clock domain.
module uart_serial_receiver_properties (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Inputs of the receiver
  input wire logic receive_enable_i,
  input wire logic sync_mode_i,
  input wire logic double_speed_bit_i,
  input wire logic [2:0] char_size_field_i,
  input wire logic [1:0] parity_mode_field_i,
  input wire logic stop_bits_select_i,
  input wire logic rx_complete_irq_enable_i,
  input wire logic global_irq_enable_i,
  input wire logic sample_tick_i,
  input wire logic serial_input_pin_i,
  input wire logic ext_transfer_clock_pin_i,
  input wire logic data_read_i,
  // Outputs of the receiver
  input wire logic [7:0] rx_data_register_o,
  input wire logic rx_ninth_bit_o,
  input wire logic frame_error_flag_o,
  input wire logic data_overrun_flag_o,
  input wire logic parity_error_flag_o,
  input wire logic rx_complete_flag_o,
  input wire logic rx_complete_irq_o,
  input wire logic pin_override_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_disable_flush: assert property (!receive_enable_i |=>
    !rx_complete_flag_o && !rx_complete_irq_o && !pin_override_o) else $error("disable did not flush");
  a_pin_follow: assert property ($past(nrst_i) |-> pin_override_o == $past(receive_enable_i))
    else $error("pin override does not follow enable");
  a_irq_follow: assert property ($past(nrst_i) |-> rx_complete_irq_o ==
    (rx_complete_flag_o && $past(rx_complete_irq_enable_i) && $past(global_irq_enable_i)))
    else $error("interrupt request wrong");
  a_empty_zero: assert property (!rx_complete_flag_o |-> {rx_data_register_o, rx_ninth_bit_o,
    frame_error_flag_o, data_overrun_flag_o, parity_error_flag_o} == 12'h000) else $error("empty entry not zero");
  a_head_stable: assert property (rx_complete_flag_o && $past(rx_complete_flag_o) &&
    !$past(data_read_i, 2) && !$past(data_read_i, 3) |-> $stable({rx_data_register_o, rx_ninth_bit_o,
    frame_error_flag_o, data_overrun_flag_o, parity_error_flag_o})) else $error("head changed without read");
  a_push_tick: assert property ($rose(rx_complete_flag_o) && !sync_mode_i |->
    $past(receive_enable_i) && ($past(sample_tick_i, 2) || $past(sample_tick_i, 3)))
    else $error("character arrived off the sample tick");
  a_short_zero: assert property ($rose(rx_complete_flag_o) && char_size_field_i != 3'h7 |->
    (rx_data_register_o >> (5 + char_size_field_i[1:0])) == 8'h00 && !rx_ninth_bit_o)
    else $error("unused upper bits not zero");
  a_parity_off: assert property ($rose(rx_complete_flag_o) && !parity_mode_field_i[1] |->
    !parity_error_flag_o) else $error("parity error while checking off");

  c_overrun: cover property ($rose(data_overrun_flag_o));
  c_frame_err: cover property ($rose(frame_error_flag_o));
  c_irq: cover property ($rose(rx_complete_irq_o));
endmodule : uart_serial_receiver_properties

bind uart_serial_receiver uart_serial_receiver_properties chk (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .receive_enable_i(receive_enable_i), .sync_mode_i(sync_mode_i),
  .double_speed_bit_i(double_speed_bit_i), .char_size_field_i(char_size_field_i),
  .parity_mode_field_i(parity_mode_field_i), .stop_bits_select_i(stop_bits_select_i),
  .rx_complete_irq_enable_i(rx_complete_irq_enable_i), .global_irq_enable_i(global_irq_enable_i),
  .sample_tick_i(sample_tick_i), .serial_input_pin_i(serial_input_pin_i),
  .ext_transfer_clock_pin_i(ext_transfer_clock_pin_i), .data_read_i(data_read_i),
  .rx_data_register_o(rx_data_register_o), .rx_ninth_bit_o(rx_ninth_bit_o),
  .frame_error_flag_o(frame_error_flag_o), .data_overrun_flag_o(data_overrun_flag_o),
  .parity_error_flag_o(parity_error_flag_o), .rx_complete_flag_o(rx_complete_flag_o),
  .rx_complete_irq_o(rx_complete_irq_o), .pin_override_o(pin_override_o));

// ==== tb/uart_tx_model.sv ====
// Behavioural remote transmitter driving the serial line and, in sync mode, the transfer clock.
// Assumes one caller at a time; line idles high, transfer clock stands low outside frames.
module uart_tx_model (
  // Clock
  input wire logic sys_clk_i,
  // Pins
  output logic line_o,
  output logic xck_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    line_o = 1'b1;
    xck_o = 1'b0;
  end

  // Sync bits get one slow clock pulse, well under a quarter of the system clock
  task automatic put(input logic b, input int cpb, input logic sy);
    @(negedge sys_clk_i);
    line_o = b;
    if (sy) begin
      repeat (4) @(negedge sys_clk_i);
      xck_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      xck_o = 1'b0;
    end else begin
      repeat (cpb - 1) @(negedge sys_clk_i);
    end
  endtask : put

  task automatic send(input logic [8:0] d, input int n, input logic [1:0] mp, input logic stp, input int cpb,
    input logic sy);
    logic p;
    p = mp[0];
    put(1'b0, cpb, sy);
    for (int i = 0; i < n; i++) begin
      put(d[i], cpb, sy);
      p ^= d[i];
    end
    if (mp[1]) put(p, cpb, sy);
    put(stp, cpb, sy);
    put(1'b1, cpb, 1'b0);
  endtask : send

  task automatic glitch(input int len);
    @(negedge sys_clk_i);
    line_o = 1'b0;
    repeat (len) @(negedge sys_clk_i);
    line_o = 1'b1;
  endtask : glitch
endmodule : uart_tx_model

// ==== tb/uart_serial_receiver_tb.sv ====
// Self-checking bench: frames from the transmitter model, reads through the data strobe.
// Assumes the baud tick is one pulse every four clocks, so a normal bit lasts 64 clocks.
module uart_serial_receiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT_CLK = 64;
  localparam int LIMIT = 40000;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic en = 1'b0, sync = 1'b0, dbl = 1'b0, sbs = 1'b0, ie = 1'b1, gie = 1'b1, tick = 1'b0, rd = 1'b0;
  logic [2:0] csz = 3'h3;
  logic [1:0] pmode = 2'h0;
  logic [1:0] phase = 2'h0;
  logic line, xck, ninth, ferr, ovr, perr, flag, irq, ovrd;
  logic [7:0] data;
  int errors = 0, samples_checked = 0, cycles = 0;

  initial forever #2 sys_clk_i = ~sys_clk_i;

  always @(negedge sys_clk_i) begin
    phase <= phase + 2'h1;
    tick <= (phase == 2'h3);
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors++;
      conclude();
    end
  end

  uart_serial_receiver dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .receive_enable_i(en), .sync_mode_i(sync),
    .double_speed_bit_i(dbl), .char_size_field_i(csz), .parity_mode_field_i(pmode), .stop_bits_select_i(sbs),
    .rx_complete_irq_enable_i(ie), .global_irq_enable_i(gie), .sample_tick_i(tick), .serial_input_pin_i(line),
    .ext_transfer_clock_pin_i(xck), .data_read_i(rd), .rx_data_register_o(data), .rx_ninth_bit_o(ninth),
    .frame_error_flag_o(ferr), .data_overrun_flag_o(ovr), .parity_error_flag_o(perr),
    .rx_complete_flag_o(flag), .rx_complete_irq_o(irq), .pin_override_o(ovrd));
  uart_tx_model tx (.sys_clk_i(sys_clk_i), .line_o(line), .xck_o(xck));

  task automatic cmp(input string nm, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // Reads closer than three cycles would pop entries never seen
  task automatic pop();
    rd = 1'b1;
    @(negedge sys_clk_i);
    rd = 1'b0;
    repeat (3) @(negedge sys_clk_i);
  endtask : pop

  task automatic rx(input logic [11:0] e);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 3000) begin
      @(negedge sys_clk_i);
      n++;
    end
    cmp("arrival", 12'h001, {11'h0, flag});
    cmp("entry", e, {ferr, ovr, perr, ninth, data});
    cmp("irq", {11'h0, ie & gie}, {11'h0, irq});
    pop();
  endtask : rx

  task automatic send8(input logic [8:0] d, input logic stp);
    tx.send(d, 8, 2'h0, stp, BIT_CLK, 1'b0);
  endtask : send8

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (5) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    en = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    cmp("override", 12'h1, {11'h0, ovrd});
    send8(9'h0A5, 1'b1);
    rx(12'h0A5);
    done("basic");
    for (int c = 0; c < 4; c++) begin
      csz = c[2:0];
      tx.send(9'h1FF, 5 + c, 2'h0, 1'b1, BIT_CLK, 1'b0);
      rx({4'h0, 8'hFF >> (3 - c)});
    end
    done("sizes");
    csz = 3'h7;
    for (int k = 0; k < 4; k++) begin
      pmode = {1'b1, k[0]};
      tx.send(9'h15A, 9, {1'b1, k[1]}, 1'b1, BIT_CLK, 1'b0);
      rx({2'h0, k[0] ^ k[1], 9'h15A});
    end
    pmode = 2'h0;
    csz = 3'h3;
    done("parity");
    sbs = 1'b1;
    send8(9'h03C, 1'b0);
    rx(12'h83C);
    sbs = 1'b0;
    dbl = 1'b1;
    tx.send(9'h0C3, 8, 2'h0, 1'b1, BIT_CLK / 2, 1'b0);
    rx(12'h0C3);
    dbl = 1'b0;
    tx.glitch(12);
    repeat (BIT_CLK * 2) @(negedge sys_clk_i);
    cmp("noise", 12'h0, {11'h0, flag});
    done("framing");
    for (int i = 0; i < 4; i++) send8(9'h011 << i, 1'b1);
    rx(12'h011);
    rx(12'h022);
    rx(12'h488);
    send8(9'h0F0, 1'b1);
    rx(12'h0F0);
    done("overrun");
    ie = 1'b0;
    repeat (2) send8(9'h055, 1'b1);
    cmp("pending", 12'h001, {10'h0, irq, flag});
    for (int r = 0; r < 4 && flag === 1'b1; r++) pop();
    cmp("flushed", 12'h0, {11'h0, flag});
    ie = 1'b1;
    gie = 1'b0;
    repeat (2) send8(9'h066, 1'b1);
    en = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    cmp("disabled", 12'h0, {flag, irq, ovrd, ninth, data});
    gie = 1'b1;
    en = 1'b1;
    fork
      send8(9'h0FF, 1'b1);
      begin
        repeat (BIT_CLK * 2) @(negedge sys_clk_i);
        en = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        en = 1'b1;
      end
    join
    repeat (BIT_CLK) @(negedge sys_clk_i);
    cmp("aborted", 12'h0, {11'h0, flag});
    done("disable");
    sync = 1'b1;
    tx.send(9'h0B7, 8, 2'h0, 1'b1, 8, 1'b1);
    rx(12'h0B7);
    done("sync");
    conclude();
  end
endmodule : uart_serial_receiver_tb
